// ### common/csr_pkg.sv
// constants and carrier types for the core status and reset-cause register bank
// Functional notes
// R1: indirect bank bit 1 selects banks 2-3 (100h-1FFh), 0 selects banks 0-1.
// R2: direct bank field 01 selects bank 1 (80h-FFh), 00 selects bank 0.
// R3: banks hold 128 bytes; software keeps upper direct bank bit clear.
// R4: timeout flag set on power-up, watchdog clear, sleep; cleared by watchdog timeout.
// R5: powerdown flag set on power-up or watchdog clear; cleared by sleep.
// R6: zero flag follows whether the operation result equals zero.
// R7: digit carry set on carry out of bit 3; inverted sense for borrow.
// R8: carry set on carry out of bit 7; inverted sense for borrow.
// R9: flag register: bank bit rw reset 0, timeout/powerdown read-only reset 1.
// R10: enable register bit 6 gates comparator interrupt, rw, resets 0.
// R11: flag register bit 6 set when comparator input changed.
// R12: interrupt flags set regardless of individual or global enables.
// R13: software should clear interrupt flags before enabling the interrupt.
// R14: unimplemented bits of enable, flag and reset-cause registers read 0.
// R15: power-on reset clears power-on flag, bit 1; software sets it later.
// R16: brown-out reset clears brown-out flag, bit 0; software sets it later.
// R17: brown-out flag unknown after power-up; meaningless with brown-out disabled.
// R18: flag-affecting instruction writing flag register keeps computed flags instead.
// R19: writes to timeout and powerdown flags are ignored.
// R20: flag register answers at 03h and 83h.
// R21: comparator flag sticky until software writes 0; new event beats clear.
package csr_pkg;
    localparam logic [8:0] CSR_ALU_FLAGS_ADDR_B0 = 9'h003;
    localparam logic [8:0] CSR_ALU_FLAGS_ADDR_B1 = 9'h083;
    localparam logic [8:0] CSR_IRQ_FLAG_ADDR     = 9'h00c;
    localparam logic [8:0] CSR_IRQ_ENABLE_ADDR   = 9'h08c;
    localparam logic [8:0] CSR_RESET_CAUSE_ADDR  = 9'h08e;
    localparam logic [6:0] CSR_BANK_OFFSET_MASK  = 7'h7f;

    localparam int CSR_INDIRECT_BANK_BIT   = 7;
    localparam int CSR_DIRECT_BANK_HI_BIT  = 6;
    localparam int CSR_DIRECT_BANK_LO_BIT  = 5;
    localparam int CSR_TIMEOUT_BIT         = 4;
    localparam int CSR_POWERDOWN_BIT       = 3;
    localparam int CSR_Z_BIT               = 2;
    localparam int CSR_DIGIT_CARRY_BIT     = 1;
    localparam int CSR_C_BIT               = 0;
    localparam int CSR_CMP_IRQ_BIT         = 6;
    localparam int CSR_POR_BIT             = 1;
    localparam int CSR_BROWNOUT_BIT        = 0;

    localparam logic [7:0] CSR_ALU_FLAGS_RESET   = 8'h18;
    localparam logic [7:0] CSR_IRQ_FLAG_RESET    = 8'h00;
    localparam logic [7:0] CSR_IRQ_ENABLE_RESET  = 8'h00;
    localparam logic [7:0] CSR_RESET_CAUSE_RESET = 8'h00;

    typedef struct packed {
        logic       sel;
        logic       wr;
        logic [8:0] addr;
        logic [7:0] wdata;
    } csr_access_t;

    typedef struct packed {
        logic       upd;
        logic       z;
        logic       digit_carry_upd;
        logic       digit_carry;
        logic       c_upd;
        logic       c;
    } csr_alu_t;

    typedef struct packed {
        logic       por;
        logic       brownout;
        logic       wdt_timeout;
        logic       watchdog_clear;
        logic       sleep;
    } csr_event_t;
endpackage : csr_pkg

// ### hdl/csr_core_status.sv
// core status, bank select, comparator interrupt and reset-cause registers
module csr_core_status
    import csr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire csr_access_t acc,
    input  wire csr_alu_t    alu,
    input  wire csr_event_t  evt,
    input  wire logic        cmp_change,
    output logic [7:0]       rdata,
    output logic [7:0]       status_out,
    output logic             indirect_bank_out,
    output logic [1:0]       rp_out,
    output logic             cmp_irq_enable,
    output logic             cmp_irq_flag,
    output logic             cmp_irq_pending
);

    typedef struct packed {
        logic [7:0] status;
        logic       cmp_en;
        logic       cmp_fl;
        logic       cmp_pend;
        logic       por_n;
        logic       brownout_n;
        logic [7:0] rdata;
    } csr_state_t;

    csr_state_t s_q;
    csr_state_t s_d;

    function automatic logic hit_status(input logic [8:0] a);
        hit_status = (a[6:0] == CSR_ALU_FLAGS_ADDR_B0[6:0]); // R20
    endfunction

    function automatic logic hit(input logic [8:0] a, input logic [8:0] r);
        hit = (a[7:0] == r[7:0]);
    endfunction

    logic wr_st;
    logic wr_fl;
    logic wr_en;
    logic wr_rc;

    always_comb
    begin
        s_d   = s_q;
        wr_st = acc.sel && acc.wr && hit_status(acc.addr);
        wr_fl = acc.sel && acc.wr && hit(acc.addr, CSR_IRQ_FLAG_ADDR);
        wr_en = acc.sel && acc.wr && hit(acc.addr, CSR_IRQ_ENABLE_ADDR);
        wr_rc = acc.sel && acc.wr && hit(acc.addr, CSR_RESET_CAUSE_ADDR);

        if (wr_st)
        begin
            // bank bits are plain storage; upper ones left to software
            s_d.status[CSR_INDIRECT_BANK_BIT]  = acc.wdata[CSR_INDIRECT_BANK_BIT]; // R1
            s_d.status[CSR_DIRECT_BANK_HI_BIT] = acc.wdata[CSR_DIRECT_BANK_HI_BIT]; // R2
            s_d.status[CSR_DIRECT_BANK_LO_BIT] = acc.wdata[CSR_DIRECT_BANK_LO_BIT]; // R2
            s_d.status[CSR_Z_BIT]              = acc.wdata[CSR_Z_BIT];
            s_d.status[CSR_DIGIT_CARRY_BIT]    = acc.wdata[CSR_DIGIT_CARRY_BIT];
            s_d.status[CSR_C_BIT]              = acc.wdata[CSR_C_BIT];
        end
        // computed flags override a write in the same instruction
        if (alu.upd)
        begin
            s_d.status[CSR_Z_BIT] = alu.z; // R6 R18
        end
        if (alu.digit_carry_upd)
        begin
            s_d.status[CSR_DIGIT_CARRY_BIT] = alu.digit_carry; // R7 R18
        end
        if (alu.c_upd)
        begin
            s_d.status[CSR_C_BIT] = alu.c; // R8 R18
        end

        // timeout and powerdown never take written data
        if (evt.wdt_timeout)
        begin
            s_d.status[CSR_TIMEOUT_BIT] = 1'b0; // R4 R19
        end
        else if (evt.watchdog_clear || evt.sleep)
        begin
            s_d.status[CSR_TIMEOUT_BIT] = 1'b1; // R4
        end
        if (evt.watchdog_clear)
        begin
            s_d.status[CSR_POWERDOWN_BIT] = 1'b1; // R5
        end
        else if (evt.sleep)
        begin
            s_d.status[CSR_POWERDOWN_BIT] = 1'b0; // R5
        end

        if (wr_en)
        begin
            s_d.cmp_en = acc.wdata[CSR_CMP_IRQ_BIT]; // R10
        end
        if (wr_fl)
        begin
            s_d.cmp_fl = acc.wdata[CSR_CMP_IRQ_BIT];
        end
        if (cmp_change)
        begin
            s_d.cmp_fl = 1'b1; // R11 R12 R21
        end
        // registered so the output comes from a flop, same cycle as flag
        s_d.cmp_pend = s_d.cmp_fl & s_d.cmp_en; // R10

        if (wr_rc)
        begin
            s_d.por_n      = acc.wdata[CSR_POR_BIT];
            s_d.brownout_n = acc.wdata[CSR_BROWNOUT_BIT];
        end
        if (evt.por)
        begin
            // power-up restores timeout and powerdown too
            s_d.por_n = 1'b0; // R15
            s_d.status[CSR_TIMEOUT_BIT] = 1'b1; // R4
            s_d.status[CSR_POWERDOWN_BIT] = 1'b1; // R5
        end
        if (evt.brownout)
        begin
            s_d.brownout_n = 1'b0; // R16
        end

        s_d.rdata = 8'h00; // R14
        if (acc.sel && !acc.wr)
        begin
            if (hit_status(acc.addr))
            begin
                s_d.rdata = s_q.status;
            end
            else if (hit(acc.addr, CSR_IRQ_FLAG_ADDR))
            begin
                s_d.rdata[CSR_CMP_IRQ_BIT] = s_q.cmp_fl; // R14
            end
            else if (hit(acc.addr, CSR_IRQ_ENABLE_ADDR))
            begin
                s_d.rdata[CSR_CMP_IRQ_BIT] = s_q.cmp_en; // R14
            end
            else if (hit(acc.addr, CSR_RESET_CAUSE_ADDR))
            begin
                s_d.rdata[CSR_POR_BIT]      = s_q.por_n; // R14
                s_d.rdata[CSR_BROWNOUT_BIT] = s_q.brownout_n;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // arithmetic flags are unknown in hardware; zero is chosen here
            s_q.status <= CSR_ALU_FLAGS_RESET; // R9
            s_q.cmp_en     <= CSR_IRQ_ENABLE_RESET[CSR_CMP_IRQ_BIT];
            s_q.cmp_fl     <= CSR_IRQ_FLAG_RESET[CSR_CMP_IRQ_BIT];
            s_q.cmp_pend   <= 1'b0;
            s_q.por_n      <= CSR_RESET_CAUSE_RESET[CSR_POR_BIT];
            s_q.brownout_n <= CSR_RESET_CAUSE_RESET[CSR_BROWNOUT_BIT];
            s_q.rdata      <= 8'h00;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rdata           = s_q.rdata;
    assign status_out      = s_q.status;
    assign indirect_bank_out = s_q.status[CSR_INDIRECT_BANK_BIT];
    assign rp_out            = s_q.status[CSR_DIRECT_BANK_HI_BIT:CSR_DIRECT_BANK_LO_BIT];
    assign cmp_irq_enable    = s_q.cmp_en;
    assign cmp_irq_flag      = s_q.cmp_fl;
    assign cmp_irq_pending   = s_q.cmp_pend;

endmodule // csr_core_status

// ### tb/csr_core_model.sv
// core model issuing register accesses, flag updates and events
module csr_core_model
    import csr_pkg::*;
(
    input  wire logic   clk,
    output csr_access_t acc,
    output csr_alu_t    alu,
    output csr_event_t  evt,
    output logic        cmp
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        acc = '0;
        alu = '0;
        evt = '0;
        cmp = 1'b0;
    end
    task automatic cyc(csr_access_t a, csr_alu_t l, csr_event_t e, logic c);
        @(posedge clk);
        #1;
        acc = a;
        alu = l;
        evt = e;
        cmp = c;
        @(posedge clk);
        #1;
        // released bus drops select and drives the inverted address and data
        acc = {1'b0, ~a.wr, ~a.addr, ~a.wdata};
        alu = '0;
        evt = '0;
        cmp = 1'b0;
    endtask
endmodule // csr_core_model

// ### tb/csr_core_status_asserts.sv
// port assertions for the core status register bank
module csr_core_status_asserts
    import csr_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire csr_access_t acc,
    input wire csr_alu_t    alu,
    input wire csr_event_t  evt,
    input wire logic        cmp_change,
    input wire logic [7:0]  rdata,
    input wire logic [7:0]  status_out,
    input wire logic        indirect_bank_out,
    input wire logic [1:0]  rp_out,
    input wire logic        cmp_irq_enable,
    input wire logic        cmp_irq_flag,
    input wire logic        cmp_irq_pending
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_cmp_flag_set: assert property (cmp_change |=> cmp_irq_flag)
        else $error("comparator flag not set");
    a_pending_and: assert property (cmp_irq_pending == (cmp_irq_flag && cmp_irq_enable))
        else $error("pending not flag and enable");
    a_wdt_clears_to: assert property (evt.wdt_timeout && !evt.por |=> !status_out[4])
        else $error("timeout flag not cleared");
    a_sleep_clears_pd: assert property (evt.sleep && !evt.watchdog_clear && !evt.por |=> !status_out[3])
        else $error("powerdown flag not cleared");
    a_zero_follows: assert property (alu.upd |=> status_out[2] == $past(alu.z))
        else $error("zero flag wrong");
    a_unused_bits: assert property (acc.sel && !acc.wr && acc.addr[7:0] == 8'h0c |=> (rdata & 8'hbf) == 8'h00)
        else $error("unused bits not zero");
    a_bank_map: assert property (indirect_bank_out == status_out[7] && rp_out == status_out[6:5])
        else $error("bank selects differ");
    a_flags_no_write: assert property (acc.sel && acc.wr && evt == '0 |=> $stable(status_out[4:3]))
        else $error("read-only flags written");
endmodule // csr_core_status_asserts

bind csr_core_status csr_core_status_asserts u_chk (.*);

// ### tb/tb_core_status_reset_cause_regs.sv
// self-checking bench for the core status and reset-cause registers
module tb_core_status_reset_cause_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import csr_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    int          err_total = 0;
    int          checks_done = 0;
    csr_access_t acc;
    csr_alu_t    alu;
    csr_event_t  evt;
    logic        cm;
    logic [7:0]  rdata;
    logic [7:0]  st;
    logic        ibank;
    logic [1:0]  rp;
    logic        ie;
    logic        fl;
    logic        pend;
    always #25 clk = ~clk;
    csr_core_status u_dut (.clk(clk), .rst_b(rst_b), .acc(acc), .alu(alu), .evt(evt),
        .cmp_change(cm), .rdata(rdata), .status_out(st), .indirect_bank_out(ibank), .rp_out(rp),
        .cmp_irq_enable(ie), .cmp_irq_flag(fl), .cmp_irq_pending(pend));
    csr_core_model u_core (.clk(clk), .acc(acc), .alu(alu), .evt(evt), .cmp(cm));
    task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
            err_total++;
        end
    endtask
    task automatic wr(logic [8:0] a, logic [7:0] v);
        u_core.cyc({2'b11, a, v}, '0, '0, 1'b0);
    endtask
    task automatic rd(logic [8:0] a, logic [7:0] exp);
        u_core.cyc({2'b10, a, 8'h00}, '0, '0, 1'b0);
        chk("rdata", rdata, exp);
    endtask
    task automatic t_regs;
        rd(9'h003, 8'h18);
        rd(9'h083, 8'h18);
        rd(9'h08c, 8'h00);
        rd(9'h00d, 8'h00);
        wr(9'h083, 8'ha7);
        chk("status", st, 8'hbf);
        chk("banks", {5'h0, ibank, rp}, 8'h05);
        wr(9'h003, 8'h00);
        chk("banks", {5'h0, ibank, rp}, 8'h00);
        u_core.cyc('0, '0, 5'b00001, 1'b0);
        chk("sleep", st, 8'h10);
        u_core.cyc('0, '0, 5'b00100, 1'b0);
        chk("wdt", st, 8'h00);
        u_core.cyc('0, '0, 5'b00010, 1'b0);
        chk("watchdog_clear_instr", st, 8'h18);
        u_core.cyc({2'b11, 9'h003, 8'h07}, 6'b101011, '0, 1'b0);
        chk("alu over write", st, 8'h19);
        u_core.cyc('0, 6'b111100, '0, 1'b0);
        chk("alu flags", st, 8'h1f);
    endtask
    task automatic t_irq;
        wr(9'h00c, 8'h00);
        u_core.cyc('0, '0, '0, 1'b1);
        chk("irq", {5'h0, ie, fl, pend}, 8'h02);
        rd(9'h00c, 8'h40);
        u_core.cyc({2'b11, 9'h00c, 8'h00}, '0, '0, 1'b1);
        chk("irq", {5'h0, ie, fl, pend}, 8'h02);
        wr(9'h00c, 8'h00);
        chk("irq", {5'h0, ie, fl, pend}, 8'h00);
        wr(9'h08c, 8'hff);
        rd(9'h08c, 8'h40);
        u_core.cyc('0, '0, '0, 1'b1);
        chk("irq", {5'h0, ie, fl, pend}, 8'h07);
        wr(9'h08e, 8'hff);
        rd(9'h08e, 8'h03);
        u_core.cyc('0, '0, 5'b10000, 1'b0);
        rd(9'h08e, 8'h01);
        wr(9'h08e, 8'h03);
        u_core.cyc('0, '0, 5'b01000, 1'b0);
        rd(9'h08e, 8'h02);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        #1 rst_b = 1'b1;
        t_regs;
        t_irq;
        finish_test;
    end
    // tests need about 70 cycles; allow over ten times that
    initial
    begin
        #40000;
        err_total++;
        finish_test;
    end
endmodule // tb_core_status_reset_cause_regs
